// >>> logic/dbr_pkg.sv
// Package for the debug-register unit: register numbers, field positions, constants.
// Assumes a core that issues debug_register_move requests and reports trap sources.
package dbr_pkg;
	localparam int unsigned DBR_W = 64;
	localparam int unsigned DBR_LO_W = 32;
	localparam int unsigned DBR_NUM_BP = 4;
	// Debug register numbers
	localparam logic [2:0] DBR_N_BP0 = 3'h0;
	localparam logic [2:0] DBR_N_BP3 = 3'h3;
	localparam logic [2:0] DBR_N_ALIAS_LO = 3'h4;
	localparam logic [2:0] DBR_N_ALIAS_HI = 3'h5;
	localparam logic [2:0] DBR_N_CAUSE = 3'h6;
	localparam logic [2:0] DBR_N_CTRL = 3'h7;
	// Status fields
	localparam int unsigned CAUSE_TASK_BIT = 15;
	localparam int unsigned CAUSE_STEP_BIT = 14;
	localparam int unsigned CAUSE_ACC_BIT = 13;
	// Status bits forced to one (31:16, 11:4); bit 12 and upper half read zero
	localparam logic [63:0] CAUSE_ONES = 64'h0000_0000_FFFF_0FF0;
	localparam logic [63:0] CAUSE_WMASK = 64'h0000_0000_0000_E00F;
	// Control fields
	localparam int unsigned CTRL_GD_BIT = 13;
	localparam int unsigned CTRL_RW_LSB = 16;
	localparam logic [63:0] CTRL_WMASK = 64'h0000_0000_FFFF_23FF;
	localparam logic [63:0] CTRL_ONES = 64'h0000_0000_0000_0400;
	localparam logic [1:0] PL_KERNEL = 2'h0;
	localparam logic [1:0] RW_EXEC = 2'h0;
endpackage

// >>> logic/dbr_match.sv
// One address comparator for an address-breakpoint register.
// Assumes fetch and data addresses arrive on the core clock as one-cycle valids.
`timescale 1ns/1ps
module dbr_match (
	input wire logic [63:0] bp_addr,
	input wire logic local_en,
	input wire logic global_en,
	input wire logic [1:0] rw_kind,
	input wire logic fetch_valid,
	input wire logic [63:0] fetch_addr,
	input wire logic data_valid,
	input wire logic [63:0] data_addr,
	output logic hit
);
	// Exec kind compares fetches; others compare data references
	always_comb begin
		if (rw_kind == dbr_pkg::RW_EXEC) begin
			hit = (local_en | global_en) & fetch_valid & (fetch_addr == bp_addr);
		end else begin
			hit = (local_en | global_en) & data_valid & (data_addr == bp_addr);
		end
	end
endmodule // dbr_match

// >>> logic/dbr_unit.sv
// Debug-register unit: four address breakpoints, cause register, control, branch record.
// Assumes the core sequences traps from the one-cycle pulses this unit gives.
// Behaviour
// - Every debug register is sixty-four bits wide.
// - Legacy or compatibility: writes zero upper half, reads return low half only.
// - Long mode transfers all sixty-four bits; operand-size prefix ignored.
// - Accesses allowed only at privilege 0, otherwise general protection fault.
// - Four linear-address breakpoints trap on matching fetch or data reference.
// - Breakpoint loads accept any value without canonical checks.
// - Reserved numbers four and five alias status and control.
// - With debug extensions enabled, reserved numbers raise invalid opcode.
// - A debug trap loads the cause register with its cause.
// - Cause bit 15 task switch, 14 single step, 13 register access.
// - Cause bits 3..0 flag which breakpoint register matched.
// - Switching into a task with trap flag set raises debug trap.
// - The one-byte trap instruction goes to the breakpoint handler.
// - Single-step-all traps after every executed instruction.
// - Control-transfer stepping traps on calls, jumps, interrupts, exceptions.
// - Source and destination of control transfers are recorded for software.
// - Cause bits 31:16 and 11:4 read ones; bit 12 reads zero.
// - Hardware never clears cause bits 15:13; software clears them.
`timescale 1ns/1ps
module dbr_unit (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic mov_valid,
	input wire logic mov_write,
	input wire logic [2:0] mov_reg,
	input wire logic [63:0] mov_wdata,
	input wire logic long_mode,
	input wire logic [1:0] current_privilege_level,
	input wire logic debug_extensions_enable,
	input wire logic step_all_en,
	input wire logic step_branch_en,
	input wire logic insn_retire,
	input wire logic insn_is_transfer,
	input wire logic [63:0] xfer_src,
	input wire logic [63:0] xfer_dst,
	input wire logic task_switch,
	input wire logic task_trap_flag,
	input wire logic one_byte_trap_instruction,
	input wire logic fetch_valid,
	input wire logic [63:0] fetch_addr,
	input wire logic data_valid,
	input wire logic [63:0] data_addr,
	output logic [63:0] mov_rdata,
	output logic mov_done,
	output logic general_protection_fault,
	output logic invalid_opcode_fault,
	output logic debug_trap,
	output logic breakpoint_trap,
	output logic [63:0] last_xfer_src,
	output logic [63:0] last_xfer_dst
);
	logic [63:0] bp_q [dbr_pkg::DBR_NUM_BP];
	logic [63:0] cause_q;
	logic [63:0] cause_d;
	logic [63:0] ctrl_q;
	logic [dbr_pkg::DBR_NUM_BP-1:0] hit;
	logic [2:0] eff_reg;
	logic priv_bad;
	logic alias_bad;
	logic cause_hi_bad;
	logic acc_ok;
	logic gd_trip;
	logic wr_ok;
	logic [63:0] wval;
	logic [63:0] rval;
	logic step_ev;
	logic task_ev;
	logic bp_ev;
	logic any_ev;

	// Reserved numbers fold onto status and control
	always_comb begin
		if (mov_reg == dbr_pkg::DBR_N_ALIAS_LO) begin
			eff_reg = dbr_pkg::DBR_N_CAUSE;
		end else if (mov_reg == dbr_pkg::DBR_N_ALIAS_HI) begin
			eff_reg = dbr_pkg::DBR_N_CTRL;
		end else begin
			eff_reg = mov_reg;
		end
	end

	// Access checks and fault selection
	assign priv_bad = mov_valid & (current_privilege_level != dbr_pkg::PL_KERNEL);
	assign alias_bad = mov_valid & ~priv_bad & debug_extensions_enable
		& ((mov_reg == dbr_pkg::DBR_N_ALIAS_LO) | (mov_reg == dbr_pkg::DBR_N_ALIAS_HI));
	assign cause_hi_bad = mov_valid & ~priv_bad & ~alias_bad & mov_write & long_mode
		& (eff_reg == dbr_pkg::DBR_N_CAUSE)
		& (mov_wdata[63:32] != 32'h0000_0000);
	// General detect traps the access itself instead of performing it
	assign gd_trip = mov_valid & ~priv_bad & ~alias_bad & ctrl_q[dbr_pkg::CTRL_GD_BIT];
	assign acc_ok = mov_valid & ~priv_bad & ~alias_bad & ~cause_hi_bad & ~gd_trip;
	assign wr_ok = acc_ok & mov_write;
	// Legacy writes clear the upper half, long mode keeps all bits
	assign wval = long_mode ? mov_wdata : {32'h0000_0000, mov_wdata[31:0]};

	// Comparators, one per breakpoint register
	genvar gi;
	generate
		for (gi = 0; gi < dbr_pkg::DBR_NUM_BP; gi++) begin : g_bp
			dbr_match u_match (
				.bp_addr(bp_q[gi]),
				.local_en(ctrl_q[2*gi]),
				.global_en(ctrl_q[2*gi+1]),
				.rw_kind(ctrl_q[dbr_pkg::CTRL_RW_LSB+4*gi +: 2]),
				.fetch_valid(fetch_valid),
				.fetch_addr(fetch_addr),
				.data_valid(data_valid),
				.data_addr(data_addr),
				.hit(hit[gi])
			);
			// Any value is stored, no canonical check
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					bp_q[gi] <= 64'h0000_0000_0000_0000;
				end else if (wr_ok && eff_reg == 3'(gi)) begin
					bp_q[gi] <= wval;
				end
			end
		end
	endgenerate

	// Trap sources
	assign step_ev = insn_retire
		& (step_all_en | (step_branch_en & insn_is_transfer));
	assign task_ev = task_switch & task_trap_flag;
	assign bp_ev = |hit;
	assign any_ev = step_ev | task_ev | bp_ev | gd_trip;

	// Next cause value: software write first, events after it so a set wins over a clear
	always_comb begin
		cause_d = cause_q;
		if (wr_ok && eff_reg == dbr_pkg::DBR_N_CAUSE) begin
			cause_d = (wval & dbr_pkg::CAUSE_WMASK) | dbr_pkg::CAUSE_ONES;
		end
		// Match bits reload only on breakpoint or general-detect events
		if (bp_ev || gd_trip) begin
			cause_d[dbr_pkg::DBR_NUM_BP-1:0] = hit;
		end
		if (task_ev) begin
			cause_d[dbr_pkg::CAUSE_TASK_BIT] = 1'b1;
		end
		if (step_ev) begin
			cause_d[dbr_pkg::CAUSE_STEP_BIT] = 1'b1;
		end
		if (gd_trip) begin
			cause_d[dbr_pkg::CAUSE_ACC_BIT] = 1'b1;
		end
	end

	// Cause register, sticky bits only cleared by software or reset
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cause_q <= dbr_pkg::CAUSE_ONES;
		end else begin
			cause_q <= cause_d;
		end
	end

	// Control register
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= dbr_pkg::CTRL_ONES;
		end else if (wr_ok && eff_reg == dbr_pkg::DBR_N_CTRL) begin
			ctrl_q <= (wval & dbr_pkg::CTRL_WMASK) | dbr_pkg::CTRL_ONES;
		end
	end

	// Control-transfer record
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			last_xfer_src <= 64'h0000_0000_0000_0000;
			last_xfer_dst <= 64'h0000_0000_0000_0000;
		end else if (insn_retire && insn_is_transfer) begin
			last_xfer_src <= xfer_src;
			last_xfer_dst <= xfer_dst;
		end
	end

	// Read mux
	always_comb begin
		if (eff_reg <= dbr_pkg::DBR_N_BP3) begin
			rval = bp_q[eff_reg[1:0]];
		end else if (eff_reg == dbr_pkg::DBR_N_CAUSE) begin
			rval = cause_q;
		end else begin
			rval = ctrl_q;
		end
	end

	// Access answers, one cycle after the request
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mov_rdata <= 64'h0000_0000_0000_0000;
			mov_done <= 1'b0;
			general_protection_fault <= 1'b0;
			invalid_opcode_fault <= 1'b0;
		end else begin
			mov_done <= acc_ok;
			general_protection_fault <= priv_bad | cause_hi_bad;
			invalid_opcode_fault <= alias_bad;
			if (acc_ok && !mov_write) begin
				mov_rdata <= long_mode ? rval : {32'h0000_0000, rval[31:0]};
			end
		end
	end

	// Trap pulses
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			debug_trap <= 1'b0;
			breakpoint_trap <= 1'b0;
		end else begin
			debug_trap <= any_ev;
			breakpoint_trap <= one_byte_trap_instruction;
		end
	end

	// Checks
	property p_priv;
		@(posedge clock) disable iff (!rst_n)
		(mov_valid && current_privilege_level != dbr_pkg::PL_KERNEL)
			|=> general_protection_fault && !mov_done;
	endproperty
	a_priv: assert property (p_priv) else $error("unprivileged access not faulted");
	property p_alias_ud;
		@(posedge clock) disable iff (!rst_n)
		(mov_valid && current_privilege_level == dbr_pkg::PL_KERNEL && debug_extensions_enable
			&& mov_reg == dbr_pkg::DBR_N_ALIAS_HI) |=> invalid_opcode_fault;
	endproperty
	a_alias_ud: assert property (p_alias_ud) else $error("reserved number not refused");
	property p_task;
		@(posedge clock) disable iff (!rst_n)
		(task_switch && task_trap_flag) |=> debug_trap && cause_q[dbr_pkg::CAUSE_TASK_BIT];
	endproperty
	a_task: assert property (p_task) else $error("task trap missing");
	property p_step;
		@(posedge clock) disable iff (!rst_n)
		(insn_retire && step_all_en) |=> debug_trap && cause_q[dbr_pkg::CAUSE_STEP_BIT];
	endproperty
	a_step: assert property (p_step) else $error("single step trap missing");
	property p_sticky;
		@(posedge clock) disable iff (!rst_n)
		(cause_q[15:13] != 3'h0 && !mov_valid)
			|=> $past(cause_q[15:13]) == (cause_q[15:13] & $past(cause_q[15:13]));
	endproperty
	a_sticky: assert property (p_sticky) else $error("cause bit dropped by hardware");
	property p_fixed;
		@(posedge clock) disable iff (!rst_n)
		(cause_q[31:16] == 16'hFFFF) && (cause_q[11:4] == 8'hFF) && !cause_q[12]
			&& cause_q[63:32] == 32'h0;
	endproperty
	a_fixed: assert property (p_fixed) else $error("cause fixed bits wrong");
	property p_legacy_rd;
		@(posedge clock) disable iff (!rst_n)
		(acc_ok && !mov_write && !long_mode) |=> mov_rdata[63:32] == 32'h0000_0000;
	endproperty
	a_legacy_rd: assert property (p_legacy_rd) else $error("legacy read upper half nonzero");
	property p_bp;
		@(posedge clock) disable iff (!rst_n)
		(hit[0]) |=> debug_trap ##0 cause_q[0];
	endproperty
	a_bp: assert property (p_bp) else $error("breakpoint 0 hit not reported");
	property p_trap_insn;
		@(posedge clock) disable iff (!rst_n)
		one_byte_trap_instruction |=> breakpoint_trap;
	endproperty
	a_trap_insn: assert property (p_trap_insn) else $error("breakpoint trap missing");
	property p_xfer;
		@(posedge clock) disable iff (!rst_n)
		(insn_retire && insn_is_transfer) |=> last_xfer_dst == $past(xfer_dst);
	endproperty
	a_xfer: assert property (p_xfer) else $error("transfer not recorded");
	property p_xfer_src;
		@(posedge clock) disable iff (!rst_n)
		(insn_retire && insn_is_transfer) |=> last_xfer_src == $past(xfer_src);
	endproperty
	a_xfer_src: assert property (p_xfer_src) else $error("transfer source lost");
	property p_lo_ud;
		@(posedge clock) disable iff (!rst_n)
		(mov_valid && current_privilege_level == dbr_pkg::PL_KERNEL && debug_extensions_enable
			&& mov_reg == dbr_pkg::DBR_N_ALIAS_LO) |=> invalid_opcode_fault && !mov_done;
	endproperty
	a_lo_ud: assert property (p_lo_ud) else $error("low alias not refused");
	property p_lo_rd;
		@(posedge clock) disable iff (!rst_n)
		(acc_ok && !mov_write && long_mode && mov_reg == dbr_pkg::DBR_N_ALIAS_LO)
			|=> mov_done && mov_rdata == $past(cause_q);
	endproperty
	a_lo_rd: assert property (p_lo_rd) else $error("low alias read wrong");
	property p_hi_rd;
		@(posedge clock) disable iff (!rst_n)
		(acc_ok && !mov_write && long_mode && mov_reg == dbr_pkg::DBR_N_ALIAS_HI)
			|=> mov_done && mov_rdata == $past(ctrl_q);
	endproperty
	a_hi_rd: assert property (p_hi_rd) else $error("high alias read wrong");
	property p_leg_wr;
		@(posedge clock) disable iff (!rst_n)
		(wr_ok && !long_mode && eff_reg <= dbr_pkg::DBR_N_BP3)
			|=> bp_q[$past(eff_reg[1:0])][63:32] == 32'h0000_0000;
	endproperty
	a_leg_wr: assert property (p_leg_wr) else $error("legacy write kept upper half");
	property p_long_wr;
		@(posedge clock) disable iff (!rst_n)
		(wr_ok && long_mode && eff_reg == dbr_pkg::DBR_N_BP0) |=> bp_q[0] == $past(mov_wdata);
	endproperty
	a_long_wr: assert property (p_long_wr) else $error("long write not stored");
	property p_long_rd;
		@(posedge clock) disable iff (!rst_n)
		(acc_ok && !mov_write && long_mode && eff_reg == dbr_pkg::DBR_N_BP0)
			|=> mov_rdata == $past(bp_q[0]);
	endproperty
	a_long_rd: assert property (p_long_rd) else $error("long read wrong");
	property p_gd;
		@(posedge clock) disable iff (!rst_n)
		gd_trip |=> debug_trap && cause_q[dbr_pkg::CAUSE_ACC_BIT] && !mov_done;
	endproperty
	a_gd: assert property (p_gd) else $error("general detect not trapped");
	property p_branch;
		@(posedge clock) disable iff (!rst_n)
		(insn_retire && step_branch_en && insn_is_transfer)
			|=> debug_trap && cause_q[dbr_pkg::CAUSE_STEP_BIT];
	endproperty
	a_branch: assert property (p_branch) else $error("transfer step trap missing");
	property p_bp_load;
		@(posedge clock) disable iff (!rst_n)
		(|hit) |=> debug_trap && cause_q[dbr_pkg::DBR_NUM_BP-1:0] == $past(hit);
	endproperty
	a_bp_load: assert property (p_bp_load) else $error("match bits not loaded");
	property p_one_ans;
		@(posedge clock) disable iff (!rst_n)
		mov_valid |=> $onehot0({mov_done, general_protection_fault, invalid_opcode_fault});
	endproperty
	a_one_ans: assert property (p_one_ans) else $error("more than one answer");
	property p_gp_keep;
		@(posedge clock) disable iff (!rst_n)
		(mov_valid && mov_write && current_privilege_level != dbr_pkg::PL_KERNEL)
			|=> $stable(ctrl_q) && $stable(bp_q[0]) && $stable(bp_q[1])
			&& $stable(bp_q[2]) && $stable(bp_q[3]);
	endproperty
	a_gp_keep: assert property (p_gp_keep) else $error("refused write stored");
endmodule // dbr_unit

// >>> sim/dbr_unit_tb.sv
// Self-checking bench for the debug-register unit: table of moves, then event cases.
// Assumes dbr_pkg and dbr_unit are compiled first; inputs change on falling edges.
`timescale 1ns/1ps
module dbr_unit_tb;
	typedef struct {logic lm; logic [1:0] pl; logic dx; logic wr; logic [2:0] rg;
		logic [63:0] d; logic [2:0] res; logic [63:0] rd;} dbr_row_t;
	localparam logic [63:0] C1 = dbr_pkg::CAUSE_ONES;
	localparam logic [63:0] K1 = dbr_pkg::CTRL_ONES;
	localparam logic [63:0] BPA = 64'hDEAD_BEEF_0123_4567;
	logic clock, rst_n, mov_valid, mov_write, long_mode, debug_extensions_enable;
	logic step_all_en, step_branch_en, insn_retire, insn_is_transfer, task_switch;
	logic task_trap_flag, one_byte_trap_instruction, fetch_valid, data_valid;
	logic mov_done, general_protection_fault, invalid_opcode_fault, debug_trap, breakpoint_trap;
	logic [2:0] mov_reg;
	logic [1:0] current_privilege_level;
	logic [63:0] mov_wdata, xfer_src, xfer_dst, fetch_addr, data_addr;
	logic [63:0] mov_rdata, last_xfer_src, last_xfer_dst;
	int failures, total_checks;
	dbr_row_t rows [20];

	dbr_unit dbr_unit_i (.clock(clock), .rst_n(rst_n), .mov_valid(mov_valid),
		.mov_write(mov_write), .mov_reg(mov_reg), .mov_wdata(mov_wdata), .long_mode(long_mode),
		.current_privilege_level(current_privilege_level),
		.debug_extensions_enable(debug_extensions_enable), .step_all_en(step_all_en),
		.step_branch_en(step_branch_en), .insn_retire(insn_retire),
		.insn_is_transfer(insn_is_transfer), .xfer_src(xfer_src), .xfer_dst(xfer_dst),
		.task_switch(task_switch), .task_trap_flag(task_trap_flag),
		.one_byte_trap_instruction(one_byte_trap_instruction), .fetch_valid(fetch_valid),
		.fetch_addr(fetch_addr), .data_valid(data_valid), .data_addr(data_addr),
		.mov_rdata(mov_rdata), .mov_done(mov_done),
		.general_protection_fault(general_protection_fault),
		.invalid_opcode_fault(invalid_opcode_fault), .debug_trap(debug_trap),
		.breakpoint_trap(breakpoint_trap), .last_xfer_src(last_xfer_src),
		.last_xfer_dst(last_xfer_dst));

	// Core clock, 5 ns period
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	// Compare any result, widened to 64 bits
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One register move; answer flags {done,gp,ud} sampled the cycle after it is taken
	task automatic acc(input dbr_row_t r);
		@(negedge clock);
		long_mode = r.lm;
		current_privilege_level = r.pl;
		debug_extensions_enable = r.dx;
		mov_write = r.wr;
		mov_reg = r.rg;
		mov_wdata = r.d;
		mov_valid = 1'b1;
		@(negedge clock);
		mov_valid = 1'b0;
		chk({61'h0, mov_done, general_protection_fault, invalid_opcode_fault}, {61'h0, r.res});
		if (!r.wr && r.res === 3'h4) begin
			chk(mov_rdata, r.rd);
		end
	endtask

	// One-cycle event pulse {fetch,data,retire,task,trap insn}, then trap outputs checked
	task automatic ev(input logic [4:0] v, input logic edb, input logic ebp);
		@(negedge clock);
		{fetch_valid, data_valid, insn_retire, task_switch, one_byte_trap_instruction} = v;
		@(negedge clock);
		{fetch_valid, data_valid, insn_retire, task_switch, one_byte_trap_instruction} = 5'h00;
		chk({63'h0, debug_trap}, {63'h0, edb});
		chk({63'h0, breakpoint_trap}, {63'h0, ebp});
	endtask

	// Verdict and end of run
	task automatic end_of_test();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Watchdog well beyond the hundred or so cycles the tests need
	initial begin
		repeat (2000) @(posedge clock);
		failures++;
		end_of_test();
	end

	// Main sequence
	initial begin
		{mov_valid, mov_write, long_mode, debug_extensions_enable} = 4'h0;
		{step_all_en, step_branch_en, insn_retire, insn_is_transfer} = 4'h0;
		{task_switch, task_trap_flag, one_byte_trap_instruction, fetch_valid, data_valid} = 5'h00;
		current_privilege_level = 2'h0;
		mov_reg = 3'h0;
		{mov_wdata, xfer_src, xfer_dst, fetch_addr, data_addr} = '0;
		failures = 0;
		total_checks = 0;
		rst_n = 1'b0;
		rows = '{
			'{1'b1, 2'h0, 1'b0, 1'b0, 3'h6, 64'h0, 3'h4, C1},
			'{1'b1, 2'h0, 1'b0, 1'b0, 3'h7, 64'h0, 3'h4, K1},
			'{1'b1, 2'h0, 1'b0, 1'b0, 3'h0, 64'h0, 3'h4, 64'h0},
			'{1'b1, 2'h0, 1'b0, 1'b1, 3'h0, BPA, 3'h4, 64'h0},
			'{1'b1, 2'h0, 1'b0, 1'b0, 3'h0, 64'h0, 3'h4, BPA},
			'{1'b0, 2'h0, 1'b0, 1'b0, 3'h0, 64'h0, 3'h4, 64'h0123_4567},
			'{1'b0, 2'h0, 1'b0, 1'b1, 3'h1, 64'hFFFF_FFFF_8000_0000, 3'h4, 64'h0},
			'{1'b1, 2'h0, 1'b0, 1'b0, 3'h1, 64'h0, 3'h4, 64'h8000_0000},
			'{1'b1, 2'h3, 1'b0, 1'b0, 3'h3, 64'h0, 3'h2, 64'h0},
			'{1'b1, 2'h1, 1'b0, 1'b1, 3'h2, 64'h5, 3'h2, 64'h0},
			'{1'b1, 2'h0, 1'b0, 1'b0, 3'h4, 64'h0, 3'h4, C1},
			'{1'b1, 2'h0, 1'b0, 1'b0, 3'h5, 64'h0, 3'h4, K1},
			'{1'b1, 2'h0, 1'b1, 1'b0, 3'h5, 64'h0, 3'h1, 64'h0},
			'{1'b1, 2'h0, 1'b1, 1'b1, 3'h4, 64'h0, 3'h1, 64'h0},
			'{1'b1, 2'h0, 1'b0, 1'b1, 3'h6, 64'h1_0000_0000, 3'h2, 64'h0},
			'{1'b0, 2'h0, 1'b0, 1'b1, 3'h6, 64'hFFFF_FFFF_0000_FFFF, 3'h4, 64'h0},
			'{1'b1, 2'h0, 1'b0, 1'b0, 3'h6, 64'h0, 3'h4, C1 | 64'hE00F},
			'{1'b1, 2'h0, 1'b0, 1'b1, 3'h6, 64'h0, 3'h4, 64'h0},
			'{1'b1, 2'h0, 1'b0, 1'b1, 3'h7, 64'h1, 3'h4, 64'h0},
			'{1'b1, 2'h0, 1'b0, 1'b0, 3'h7, 64'h0, 3'h4, K1 | 64'h1}};
		repeat (16) @(negedge clock);
		rst_n = 1'b1;
		foreach (rows[i]) begin
			acc(rows[i]);
		end
		fetch_addr = BPA;
		data_addr = BPA;
		ev(5'h08, 1'b0, 1'b0);
		ev(5'h10, 1'b1, 1'b0);
		acc('{1'b1, 2'h0, 1'b0, 1'b0, 3'h6, 64'h0, 3'h4, C1 | 64'h1});
		fetch_addr = BPA ^ 64'h1;
		ev(5'h10, 1'b0, 1'b0);
		step_all_en = 1'b1;
		ev(5'h04, 1'b1, 1'b0);
		step_all_en = 1'b0;
		acc('{1'b1, 2'h0, 1'b0, 1'b0, 3'h6, 64'h0, 3'h4, C1 | 64'h4001});
		ev(5'h02, 1'b0, 1'b0);
		task_trap_flag = 1'b1;
		ev(5'h02, 1'b1, 1'b0);
		acc('{1'b1, 2'h0, 1'b0, 1'b0, 3'h6, 64'h0, 3'h4, C1 | 64'hC001});
		step_branch_en = 1'b1;
		ev(5'h04, 1'b0, 1'b0);
		insn_is_transfer = 1'b1;
		xfer_src = 64'h1111_2222_3333_4444;
		xfer_dst = 64'h5555_6666_7777_8888;
		ev(5'h04, 1'b1, 1'b0);
		chk(last_xfer_src, 64'h1111_2222_3333_4444);
		chk(last_xfer_dst, 64'h5555_6666_7777_8888);
		insn_is_transfer = 1'b0;
		step_branch_en = 1'b0;
		ev(5'h01, 1'b0, 1'b1);
		// Data breakpoint on register 1, write kind, global enable
		acc('{1'b1, 2'h0, 1'b0, 1'b1, 3'h7, 64'h0010_0008, 3'h4, 64'h0});
		data_addr = 64'h8000_0000;
		ev(5'h08, 1'b1, 1'b0);
		acc('{1'b1, 2'h0, 1'b0, 1'b0, 3'h6, 64'h0, 3'h4, C1 | 64'hC002});
		acc('{1'b1, 2'h0, 1'b0, 1'b1, 3'h7, 64'h2001, 3'h4, 64'h0});
		acc('{1'b1, 2'h0, 1'b0, 1'b0, 3'h0, 64'h0, 3'h0, 64'h0});
		chk({63'h0, debug_trap}, 64'h1);
		// Mid-run reset clears traps, control, record and sticky cause bits
		rst_n = 1'b0;
		@(negedge clock);
		chk({63'h0, debug_trap}, 64'h0);
		chk(last_xfer_dst, 64'h0);
		rst_n = 1'b1;
		acc('{1'b1, 2'h0, 1'b0, 1'b0, 3'h7, 64'h0, 3'h4, K1});
		acc('{1'b1, 2'h0, 1'b0, 1'b0, 3'h6, 64'h0, 3'h4, C1});
		// Cause clear and flagged task switch in one cycle: the set wins
		@(negedge clock);
		{mov_valid, mov_write, task_switch} = 3'h7;
		mov_reg = 3'h6;
		mov_wdata = 64'h0;
		@(negedge clock);
		{mov_valid, mov_write, task_switch} = 3'h0;
		chk({63'h0, mov_done}, 64'h1);
		chk({63'h0, debug_trap}, 64'h1);
		acc('{1'b1, 2'h0, 1'b0, 1'b0, 3'h6, 64'h0, 3'h4, C1 | 64'h8000});
		end_of_test();
	end
endmodule // dbr_unit_tb
